// file: rtl/disk_datapath_defines.vh
// constants for the cartridge disk controller datapath
// Contract
// - csr bit 00 reads drive ready
// - seek command waits for drive ready
// - sequencer step stalls while drive not ready
// - csr bit 14 reads drive error
// - sector pulse clears, gates, resets, counts
// - sixteen status bits shifted into silo
// - csr 15:10 and 00 read-only live
// - address bits 17:16 via csr 05:04
// - address register bits 15:01, bit 00 unused
// - each transfer drives address then increments
// - disk address readable, writable, bits 15:02 serialized out
// - disk address compared against read header
// - disk address increments at sector end
// - word count load, increment, overflow done
// - word counter never readable by cpu
// - 16x16 silo feeds cpu and memory
// - memory words serialized toward drive
// - silo input selects data or status
// - write check mismatch sets error flags
// - crc appended on write, checked on read
// - command sixteen bits, marker, function bit
// - command bit 03 clears drive errors
// - drive select lines from csr 09:08
`ifndef DISK_DATAPATH_DEFINES_VH
`define DISK_DATAPATH_DEFINES_VH

// register select indices
`define REG_CONTROL_STATUS 2'h0
`define REG_MEMORY_ADDRESS 2'h1
`define REG_DISK_ADDRESS 2'h2
`define REG_MULTIPURPOSE 2'h3

// control_status fields
`define CSR_DRIVE_READY 0
`define CSR_FUNC_LO 1
`define CSR_FUNC_HI 3
`define CSR_ADDR_LO 4
`define CSR_ADDR_HI 5
`define CSR_SEL_LO 8
`define CSR_SEL_HI 9
`define CSR_HDR_ERR 10
`define CSR_CRC_ERR 11
`define CSR_DRIVE_ERR 14
`define CSR_COMPOSITE 15

// reset values
`define CSR_RESET 16'h0000
`define ADDR_RESET 18'h0_0000
`define MEM_ADDR_RESET 17'h0_0000
`define DISK_ADDR_RESET 16'h0000
`define WORD_COUNT_RESET 16'h0000
`define CRC_INIT 16'h0000
`define CRC_POLY 16'h8005

// drive command fields
`define CMD_MARKER 0
`define CMD_FUNCTION 1
`define CMD_RESET_ERR 3

// timing: drive system clock rate against core clock
`define CORE_CLK_KHZ 100000
`define SYS_CLK_KHZ 4100
`define SYS_BIT_CYCLES (`CORE_CLK_KHZ / `SYS_CLK_KHZ)
`define SECTOR_PULSE_US 48
`define SECTOR_PERIOD_US 625

`endif

// file: rtl/silo16.v
// sixteen word by sixteen bit silo buffer
`timescale 1ns/1ps
`default_nettype none
`include "disk_datapath_defines.vh"
module silo16 (
	input wire core_clk,
	input wire rst_n,
	input wire push,
	input wire [15:0] push_data,
	input wire pop,
	output wire [15:0] out_data,
	output wire empty,
	output wire full
);
	reg [15:0] mem_q [0:15];
	reg [3:0] wp_q;
	reg [3:0] rp_q;
	reg [4:0] cnt_q;
	wire do_push;
	wire do_pop;

	assign empty = (cnt_q == 5'h00);
	assign full = cnt_q[4];
	assign do_push = push & ~full;
	assign do_pop = pop & ~empty;
	assign out_data = mem_q[rp_q];

	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1) begin : g_entry
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					mem_q[i] <= 16'h0000;
				end else if (do_push && wp_q == i) begin
					mem_q[i] <= push_data;
				end
			end
		end
	endgenerate

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= 4'h0;
			rp_q <= 4'h0;
			cnt_q <= 5'h00;
		end else begin
			if (do_push) begin
				wp_q <= wp_q + 4'h1;
			end
			if (do_pop) begin
				rp_q <= rp_q + 4'h1;
			end
			if (do_push && !do_pop) begin
				cnt_q <= cnt_q + 5'h01;
			end else if (do_pop && !do_push) begin
				cnt_q <= cnt_q - 5'h01;
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/crc16_serial.v
// bit-serial crc generator and checker
`timescale 1ns/1ps
`default_nettype none
`include "disk_datapath_defines.vh"
module crc16_serial #(
	parameter [15:0] POLY = `CRC_POLY
) (
	input wire core_clk,
	input wire rst_n,
	input wire clear,
	input wire enable,
	input wire data_bit,
	output reg [15:0] crc_q
);
	wire fb;

	assign fb = data_bit ^ crc_q[15];

	// same shift for write and read
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_q <= `CRC_INIT;
		end else if (clear) begin
			crc_q <= `CRC_INIT;
		end else if (enable) begin
			crc_q <= {crc_q[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
		end
	end
endmodule
`default_nettype wire

// file: rtl/disk_controller_datapath.v
// controller-side datapath of the cartridge disk controller
`timescale 1ns/1ps
`default_nettype none
`include "disk_datapath_defines.vh"
module disk_controller_datapath (
	input wire core_clk,
	input wire rst_n,
	input wire [1:0] cpu_sel,
	input wire cpu_wr,
	input wire cpu_rd,
	input wire [15:0] cpu_wdata,
	output reg [15:0] cpu_rdata,
	input wire dmt_ack,
	input wire dmt_to_mem,
	input wire [15:0] dmt_wdata,
	output wire [15:0] dmt_rdata,
	output reg [17:0] dmt_addr,
	output reg transfer_count_done,
	output wire [2:0] function_code,
	input wire pc_step_req,
	output wire pc_step,
	input wire cmd_start,
	input wire cmd_is_seek,
	input wire status_mode,
	input wire read_mode,
	input wire write_mode,
	input wire wcheck_mode,
	input wire hdr_check,
	input wire crc_append,
	input wire crc_check,
	input wire sector_end,
	input wire clr_errors,
	input wire drive_ready_line,
	input wire drive_error_line,
	input wire sector_start_pulse,
	input wire status_clk,
	input wire status_data,
	input wire separator_clock,
	input wire separator_data,
	output wire [1:0] drive_select_lines,
	output reg drive_command_line,
	output reg write_data_line,
	output wire cmd_busy,
	output wire silo_full,
	output reg [7:0] sector_count,
	output reg [7:0] format_word_count
);
	localparam [31:0] BIT_CYCLES = `SYS_BIT_CYCLES;

	// ************************************************
	// drive input synchronisers
	// ************************************************
	wire [6:0] pins;
	reg [6:0] meta_q;
	reg [6:0] sync_q;
	reg [6:0] prev_q;
	assign pins = {separator_data, separator_clock, status_data, status_clk,
		sector_start_pulse, drive_error_line, drive_ready_line};
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 7'h00;
			sync_q <= 7'h00;
			prev_q <= 7'h00;
		end else begin
			meta_q <= pins;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	wire drv_ready = sync_q[0];
	wire drv_error = sync_q[1];
	wire sec_level = sync_q[2];
	wire sec_rise = sync_q[2] & ~prev_q[2];
	wire stat_rise = sync_q[3] & ~prev_q[3];
	wire stat_bit = sync_q[4];
	wire sep_rise = sync_q[5] & ~prev_q[5];
	wire sep_bit = sync_q[6];

	// ************************************************
	// registers
	// ************************************************
	reg [15:0] csr_q;
	reg [17:1] addr_q;
	reg [15:0] disk_addr_q;
	reg [15:0] word_count_q;
	reg hdr_err_q;
	reg crc_err_q;
	reg wc_err_q;
	wire [15:0] silo_out;
	wire silo_empty;
	wire [15:0] crc_val;
	wire wr_csr = cpu_wr && cpu_sel == `REG_CONTROL_STATUS;
	wire wr_addr = cpu_wr && cpu_sel == `REG_MEMORY_ADDRESS;
	wire wr_disk = cpu_wr && cpu_sel == `REG_DISK_ADDRESS;
	wire wr_mpr = cpu_wr && cpu_sel == `REG_MULTIPURPOSE;
	wire rd_mpr = cpu_rd && cpu_sel == `REG_MULTIPURPOSE;
	wire [15:0] csr_view;

	assign csr_view = {(hdr_err_q | crc_err_q | drv_error), drv_error, 2'b00,
		crc_err_q, hdr_err_q, csr_q[9:6], addr_q[17:16], csr_q[3:1], drv_ready};
	assign drive_select_lines = csr_q[`CSR_SEL_HI:`CSR_SEL_LO];
	assign function_code = csr_q[`CSR_FUNC_HI:`CSR_FUNC_LO];
	// step held off while not ready or in sector pulse
	assign pc_step = pc_step_req & drv_ready & ~sec_level;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			csr_q <= `CSR_RESET;
			addr_q <= `MEM_ADDR_RESET;
			disk_addr_q <= `DISK_ADDR_RESET;
			word_count_q <= `WORD_COUNT_RESET;
			transfer_count_done <= 1'b0;
			dmt_addr <= `ADDR_RESET;
		end else begin
			if (wr_csr) begin
				csr_q[9:6] <= cpu_wdata[9:6];
				csr_q[3:1] <= cpu_wdata[3:1];
			end
			if (dmt_ack) begin
				dmt_addr <= {addr_q, 1'b0};
				addr_q <= addr_q + 17'h0_0001;
			end else begin
				if (wr_addr) begin
					addr_q[15:1] <= cpu_wdata[15:1];
				end
				if (wr_csr) begin
					addr_q[17:16] <= cpu_wdata[`CSR_ADDR_HI:`CSR_ADDR_LO];
				end
			end
			// disk address access and sector step
			if (wr_disk) begin
				disk_addr_q <= cpu_wdata;
			end else if (sector_end) begin
				disk_addr_q <= disk_addr_q + 16'h0001;
			end
			if (wr_mpr) begin
				word_count_q <= cpu_wdata;
				transfer_count_done <= 1'b0;
			end else if (dmt_ack) begin
				word_count_q <= word_count_q + 16'h0001;
				if (word_count_q == 16'hFFFF) begin
					transfer_count_done <= 1'b1;
				end
			end
		end
	end

	// word counter absent from read mux
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_rdata <= 16'h0000;
		end else if (cpu_rd) begin
			case (cpu_sel)
				`REG_CONTROL_STATUS: cpu_rdata <= csr_view;
				`REG_MEMORY_ADDRESS: cpu_rdata <= {addr_q[15:1], 1'b0};
				`REG_DISK_ADDRESS: cpu_rdata <= disk_addr_q;
				default: cpu_rdata <= silo_out;
			endcase
		end
	end

	// ************************************************
	// drive system clock bit timer
	// ************************************************
	reg [4:0] tmr_q;
	wire bit_tick = (tmr_q == BIT_CYCLES[4:0] - 5'h01);
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_q <= 5'h00;
		end else begin
			tmr_q <= bit_tick ? 5'h00 : tmr_q + 5'h01;
		end
	end

	// ************************************************
	// drive command serializer
	// ************************************************
	reg [15:0] cmd_sh_q;
	reg [4:0] cmd_cnt_q;
	reg cmd_pend_q;
	reg cmd_seek_q;
	assign cmd_busy = cmd_pend_q | (cmd_cnt_q != 5'h00);
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_sh_q <= 16'h0000;
			cmd_cnt_q <= 5'h00;
			cmd_pend_q <= 1'b0;
			cmd_seek_q <= 1'b0;
			drive_command_line <= 1'b0;
		end else begin
			if (cmd_start && !cmd_busy) begin
				cmd_pend_q <= 1'b1;
				cmd_seek_q <= cmd_is_seek;
			end
			// seek waits for ready; marker, function, reset bit
			if (cmd_pend_q && bit_tick && (drv_ready || !cmd_seek_q)) begin
				cmd_pend_q <= 1'b0;
				cmd_sh_q <= {disk_addr_q[15:2], ~cmd_seek_q, 1'b1};
				cmd_cnt_q <= 5'h10;
			end else if (bit_tick && cmd_cnt_q != 5'h00) begin
				drive_command_line <= cmd_sh_q[0];
				cmd_sh_q <= {1'b0, cmd_sh_q[15:1]};
				cmd_cnt_q <= cmd_cnt_q - 5'h01;
			end else if (bit_tick) begin
				drive_command_line <= 1'b0;
			end
		end
	end

	// ************************************************
	// silo input select and deserializer
	// ************************************************
	// status or separated data source
	wire in_stb = status_mode ? stat_rise : (sep_rise & (read_mode | hdr_check));
	wire in_bit = status_mode ? stat_bit : sep_bit;
	reg [15:0] rx_sh_q;
	reg [3:0] rx_cnt_q;
	reg rx_push;
	wire [15:0] rx_word = {in_bit, rx_sh_q[15:1]};
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_sh_q <= 16'h0000;
			rx_cnt_q <= 4'h0;
		end else if (sec_rise && !status_mode) begin
			rx_cnt_q <= 4'h0;
		end else if (in_stb) begin
			rx_sh_q <= rx_word;
			rx_cnt_q <= rx_cnt_q + 4'h1;
		end
	end
	always @* begin
		rx_push = in_stb && rx_cnt_q == 4'hF;
	end

	// ************************************************
	// write serializer, write check and header compare
	// ************************************************
	reg [15:0] wr_sh_q;
	reg [4:0] wr_cnt_q;
	reg appending_q;
	reg [3:0] hdr_idx_q;
	wire wr_step = write_mode ? bit_tick : (wcheck_mode & sep_rise);
	wire wr_load = wr_step && wr_cnt_q == 5'h00 && !silo_empty && !appending_q;
	wire cpu_pop = rd_mpr;
	wire dmt_pop = dmt_ack & dmt_to_mem;
	wire dmt_push = dmt_ack & ~dmt_to_mem;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_sh_q <= 16'h0000;
			wr_cnt_q <= 5'h00;
			appending_q <= 1'b0;
			write_data_line <= 1'b0;
		end else if (sec_rise) begin
			wr_sh_q <= 16'h0000;
			wr_cnt_q <= 5'h00;
			appending_q <= 1'b0;
		end else if (crc_append && write_mode) begin
			wr_sh_q <= crc_val;
			wr_cnt_q <= 5'h10;
			appending_q <= 1'b1;
		end else if (wr_load) begin
			wr_sh_q <= silo_out;
			wr_cnt_q <= 5'h10;
		end else if (wr_step && wr_cnt_q != 5'h00) begin
			write_data_line <= wr_sh_q[15];
			wr_sh_q <= {wr_sh_q[14:0], 1'b0};
			wr_cnt_q <= wr_cnt_q - 5'h01;
			if (wr_cnt_q == 5'h01) begin
				appending_q <= 1'b0;
			end
		end
	end

	wire crc_en_wr = write_mode & wr_step & (wr_cnt_q != 5'h00) & ~appending_q;
	wire crc_en_rd = read_mode & sep_rise;
	wire wc_miss = wcheck_mode & sep_rise & (wr_cnt_q != 5'h00) & (wr_sh_q[15] ^ sep_bit);
	wire hdr_miss = hdr_check & sep_rise & (disk_addr_q[hdr_idx_q] ^ sep_bit);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hdr_err_q <= 1'b0;
			crc_err_q <= 1'b0;
			wc_err_q <= 1'b0;
			hdr_idx_q <= 4'h0;
		end else begin
			if (sec_rise) begin
				hdr_idx_q <= 4'h0;
			end else if (hdr_check && sep_rise) begin
				hdr_idx_q <= hdr_idx_q + 4'h1;
			end
			if (hdr_miss) begin
				hdr_err_q <= 1'b1;
			end else if (sec_rise || clr_errors) begin
				hdr_err_q <= 1'b0;
			end
			// mismatch sets write check and crc error
			if (wc_miss) begin
				wc_err_q <= 1'b1;
			end else if (clr_errors) begin
				wc_err_q <= 1'b0;
			end
			if (wc_miss || wc_err_q || (crc_check && crc_val != 16'h0000)) begin
				crc_err_q <= 1'b1;
			end else if (clr_errors) begin
				crc_err_q <= 1'b0;
			end
		end
	end

	// ************************************************
	// sector and format word counters
	// ************************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sector_count <= 8'h00;
			format_word_count <= 8'h00;
		end else if (sec_rise) begin
			sector_count <= sector_count + 8'h01;
			format_word_count <= 8'h00;
		end else if (rx_push || wr_load) begin
			format_word_count <= format_word_count + 8'h01;
		end
	end

	// ************************************************
	// silo and crc
	// ************************************************
	// silo feeds cpu reads and memory transfers
	silo16 u_silo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.push(rx_push | dmt_push),
		.push_data(rx_push ? rx_word : dmt_wdata),
		.pop(cpu_pop | dmt_pop | wr_load),
		.out_data(silo_out),
		.empty(silo_empty),
		.full(silo_full)
	);
	assign dmt_rdata = silo_out;

	crc16_serial #(
		.POLY(`CRC_POLY)
	) u_crc (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clear(sec_rise),
		.enable(crc_en_wr | crc_en_rd),
		.data_bit(crc_en_wr ? wr_sh_q[15] : sep_bit),
		.crc_q(crc_val)
	);
endmodule
`default_nettype wire

// file: dv/disk_controller_datapath_props.sv
// checker on the datapath ports
`timescale 1ns/1ps
`default_nettype none
module disk_controller_datapath_props (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [1:0] cpu_sel,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	input wire logic [15:0] cpu_wdata,
	input wire logic [15:0] cpu_rdata,
	input wire logic dmt_ack,
	input wire logic [17:0] dmt_addr,
	input wire logic transfer_count_done,
	input wire logic [2:0] function_code,
	input wire logic pc_step,
	input wire logic cmd_start,
	input wire logic cmd_is_seek,
	input wire logic cmd_busy,
	input wire logic drive_ready_line,
	input wire logic drive_error_line,
	input wire logic sector_start_pulse,
	input wire logic [1:0] drive_select_lines,
	input wire logic drive_command_line,
	input wire logic [7:0] format_word_count
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ****
	// port relations
	// ****
	a_ready_bit: assert property (drive_ready_line [*4] ##0 (cpu_rd && cpu_sel == 2'h0)
		|=> cpu_rdata[0]) else $error("ready bit not shown");
	a_error_bit: assert property (drive_error_line [*4] ##0 (cpu_rd && cpu_sel == 2'h0)
		|=> cpu_rdata[14] && cpu_rdata[15]) else $error("error bit not shown");
	a_live_bits: assert property (cpu_rd && cpu_sel == 2'h0 |=> cpu_rdata[13:12] == 2'b00
		&& cpu_rdata[15] == (cpu_rdata[14] | cpu_rdata[11] | cpu_rdata[10]))
		else $error("live bits wrong");
	a_select_lines: assert property (cpu_wr && cpu_sel == 2'h0
		|-> ##2 drive_select_lines == $past(cpu_wdata[9:8], 2)) else $error("select wrong");
	a_func_code: assert property (cpu_wr && cpu_sel == 2'h0
		|-> ##2 function_code == $past(cpu_wdata[3:1], 2)) else $error("function wrong");
	a_addr_word: assert property (cpu_rd && cpu_sel == 2'h1 |=> !cpu_rdata[0])
		else $error("address bit 0 set");
	a_dmt_step: assert property (dmt_ack ##1 dmt_ack
		|=> dmt_addr == $past(dmt_addr) + 18'h0_0002 && !dmt_addr[0])
		else $error("transfer address step wrong");
	a_pc_stall: assert property (!drive_ready_line [*3] |-> !pc_step)
		else $error("sequencer stepped while not ready");
	// seek taken while ready has stayed low
	logic [1:0] low_q;
	logic seek_wait_q;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_q <= 2'h0;
			seek_wait_q <= 1'b0;
		end else begin
			low_q <= drive_ready_line ? 2'h0 : ((low_q == 2'h3) ? 2'h3 : low_q + 2'h1);
			if (drive_ready_line) begin
				seek_wait_q <= 1'b0;
			end else if (cmd_start && cmd_is_seek && !cmd_busy && !drive_command_line
				&& low_q == 2'h3) begin
				seek_wait_q <= 1'b1;
			end
		end
	end
	a_seek_hold: assert property (seek_wait_q |-> !drive_command_line && cmd_busy)
		else $error("seek shifted early");
	a_count_clear: assert property (cpu_wr && cpu_sel == 2'h3 |=> !transfer_count_done)
		else $error("done not cleared");
	a_sector_reset: assert property ($rose(sector_start_pulse)
		|-> ##[3:6] format_word_count == 8'h00) else $error("format count not reset");
endmodule
bind disk_controller_datapath disk_controller_datapath_props u_props (.core_clk, .rst_n,
	.cpu_sel, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .dmt_ack, .dmt_addr,
	.transfer_count_done, .function_code, .pc_step, .cmd_start, .cmd_is_seek, .cmd_busy,
	.drive_ready_line, .drive_error_line, .sector_start_pulse, .drive_select_lines,
	.drive_command_line, .format_word_count);
`default_nettype wire

// file: dv/drive_model.sv
// behavioural drive on the serial link
`timescale 1ns/1ps
`default_nettype none
module drive_model #(
	parameter logic [1:0] UNIT = 2'b01,
	parameter logic [15:0] STATUS_WORD = 16'h5a3c,
	parameter int PULSE_NS = 48000,
	parameter int PERIOD_NS = 625000
) (
	input wire logic [1:0] drive_select_lines,
	input wire logic drive_command_line,
	input wire logic ready_ctl,
	output logic drive_ready_line,
	output logic drive_error_line,
	output logic sector_start_pulse,
	output logic status_clk,
	output logic status_data,
	output logic [15:0] last_cmd,
	output logic status_sent
);
	logic err;
	logic sel;
	logic [15:0] cmd;
	// ****
	// drive lines
	// ****
	assign sel = (drive_select_lines == UNIT);
	assign drive_ready_line = sel & ready_ctl;
	assign drive_error_line = sel & err;
	initial begin
		sector_start_pulse = 1'b0;
		forever begin
			#(PERIOD_NS - PULSE_NS);
			sector_start_pulse = 1'b1;
			#(PULSE_NS);
			sector_start_pulse = 1'b0;
		end
	end
	// command capture, error reset, status reply
	initial begin
		err = 1'b1;
		status_clk = 1'b0;
		status_data = 1'b0;
		last_cmd = 16'h0000;
		status_sent = 1'b0;
		forever begin
			@(posedge drive_command_line);
			#120;
			for (int i = 0; i < 16; i++) begin
				cmd[i] = drive_command_line;
				#240;
			end
			last_cmd = cmd;
			if (cmd[1] && sel) begin
				if (cmd[3])
					err = 1'b0;
				#400;
				for (int i = 0; i < 16; i++) begin
					status_data = STATUS_WORD[i];
					#80 status_clk = 1'b1;
					#80 status_clk = 1'b0;
				end
				status_data = ~status_data;
				status_sent = ~status_sent;
			end
		end
	end
endmodule
`default_nettype wire

// file: dv/tb_disk_controller_datapath.sv
// self-checking bench for the disk controller datapath
`timescale 1ns/1ps
`default_nettype none
module tb_disk_controller_datapath;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] cpu_sel;
	logic [15:0] cpu_wdata, dmt_wdata;
	logic cpu_wr, cpu_rd, dmt_ack, dmt_to_mem, pc_step_req, cmd_start, cmd_is_seek, status_mode;
	logic read_mode, write_mode, wcheck_mode, hdr_check, crc_append, crc_check, sector_end;
	logic clr_errors, separator_clock, separator_data, ready_ctl;
	wire [15:0] cpu_rdata, dmt_rdata, last_cmd;
	wire [17:0] dmt_addr;
	wire [2:0] function_code;
	wire [1:0] drive_select_lines;
	wire [7:0] sector_count, format_word_count;
	wire transfer_count_done, pc_step, cmd_busy, silo_full, drive_command_line, write_data_line;
	wire drive_ready_line, drive_error_line, sector_start_pulse, status_clk, status_data;
	wire status_sent;
	int failures, checks_done;
	always #5 core_clk = ~core_clk;
	disk_controller_datapath DUT (.core_clk, .rst_n, .cpu_sel, .cpu_wr, .cpu_rd, .cpu_wdata,
		.cpu_rdata, .dmt_ack, .dmt_to_mem, .dmt_wdata, .dmt_rdata, .dmt_addr,
		.transfer_count_done, .function_code, .pc_step_req, .pc_step, .cmd_start, .cmd_is_seek,
		.status_mode, .read_mode, .write_mode, .wcheck_mode, .hdr_check, .crc_append,
		.crc_check, .sector_end, .clr_errors, .drive_ready_line, .drive_error_line,
		.sector_start_pulse, .status_clk, .status_data, .separator_clock, .separator_data,
		.drive_select_lines, .drive_command_line, .write_data_line, .cmd_busy, .silo_full,
		.sector_count, .format_word_count);
	drive_model drive (.drive_select_lines, .drive_command_line, .ready_ctl,
		.drive_ready_line, .drive_error_line, .sector_start_pulse, .status_clk,
		.status_data, .last_cmd, .status_sent);
	// ****
	// helpers
	// ****
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [1:0] s, input logic [15:0] d);
		tick(1);
		cpu_sel = s;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		tick(1);
		cpu_wr = 1'b0;
	endtask
	task automatic rd(input logic [1:0] s, output logic [15:0] d);
		tick(1);
		cpu_sel = s;
		cpu_rd = 1'b1;
		tick(1);
		cpu_rd = 1'b0;
		d = cpu_rdata;
	endtask
	task automatic close_out;
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_csr;
		logic [15:0] d;
		wr(2'h0, 16'hffff);
		tick(5);
		rd(2'h0, d);
		check("csr unselected", 16'h03fe, d);
		check("select", 2'b11, drive_select_lines);
		check("function", 3'h7, function_code);
		wr(2'h0, 16'h0110);
		tick(5);
		rd(2'h0, d);
		check("csr selected", 16'hc111, d);
	endtask
	task automatic t_dmt;
		logic [15:0] d;
		wr(2'h1, 16'h1235);
		rd(2'h1, d);
		check("address", 16'h1234, d);
		wr(2'h3, 16'hfffe);
		tick(1);
		dmt_wdata = 16'ha5c3;
		dmt_ack = 1'b1;
		tick(1);
		check("dmt address", 18'h1_1234, dmt_addr);
		check("done early", 0, transfer_count_done);
		dmt_wdata = 16'h3c5a;
		tick(1);
		dmt_ack = 1'b0;
		check("dmt next", 18'h1_1236, dmt_addr);
		tick(1);
		check("done", 1, transfer_count_done);
		rd(2'h1, d);
		check("address after", 16'h1238, d);
		rd(2'h3, d);
		check("silo head", 16'ha5c3, d);
		rd(2'h3, d);
		check("silo next", 16'h3c5a, d);
		wr(2'h3, 16'h0000);
		check("done cleared", 0, transfer_count_done);
	endtask
	task automatic t_status;
		logic [15:0] d;
		logic s;
		s = status_sent;
		wr(2'h2, 16'h0008);
		status_mode = 1'b1;
		tick(1);
		cmd_start = 1'b1;
		tick(1);
		cmd_start = 1'b0;
		for (int i = 0; i < 2000 && status_sent === s; i++)
			tick(1);
		tick(10);
		check("status command", 16'h000b, last_cmd);
		rd(2'h3, d);
		check("status word", 16'h5a3c, d);
		status_mode = 1'b0;
		rd(2'h0, d);
		check("error cleared", 16'h0111, d);
	endtask
	task automatic t_seek;
		ready_ctl = 1'b0;
		pc_step_req = 1'b1;
		tick(5);
		check("stall", 0, pc_step);
		wr(2'h2, 16'h1234);
		tick(1);
		cmd_is_seek = 1'b1;
		cmd_start = 1'b1;
		tick(1);
		cmd_start = 1'b0;
		tick(100);
		check("seek held", 0, drive_command_line);
		check("seek pending", 1, cmd_busy);
		ready_ctl = 1'b1;
		for (int i = 0; i < 1000 && cmd_busy !== 1'b0; i++)
			tick(1);
		tick(60);
		check("seek command", 16'h1235, last_cmd);
		check("step", 1, pc_step);
		pc_step_req = 1'b0;
	endtask
	task automatic t_sector;
		logic [15:0] d;
		logic [7:0] n;
		n = sector_count;
		for (int i = 0; i < 60000 && sector_count === n; i++)
			tick(1);
		check("sector count", n + 8'h01, sector_count);
		tick(5);
		check("format count", 0, format_word_count);
		sector_end = 1'b1;
		tick(1);
		sector_end = 1'b0;
		rd(2'h2, d);
		check("disk address", 16'h1235, d);
	endtask
	task automatic t_write;
		logic [15:0] w;
		write_mode = 1'b1;
		tick(1);
		dmt_wdata = 16'hb2c5;
		dmt_ack = 1'b1;
		tick(1);
		dmt_ack = 1'b0;
		for (int i = 0; i < 200 && write_data_line !== 1'b1; i++)
			tick(1);
		#119;
		for (int i = 15; i >= 0; i--) begin
			w[i] = write_data_line;
			#240;
		end
		check("write data", 16'hb2c5, w);
		write_mode = 1'b0;
	endtask
	task automatic sep_bit(input logic b);
		separator_data = b;
		tick(8);
		separator_clock = 1'b1;
		tick(8);
		separator_clock = 1'b0;
	endtask
	task automatic clear_errors;
		clr_errors = 1'b1;
		tick(2);
		clr_errors = 1'b0;
	endtask
	task automatic t_serial;
		logic [15:0] d;
		// read data only outside the sector pulse
		for (int i = 0; i < 6000 && sector_start_pulse !== 1'b0; i++)
			tick(1);
		hdr_check = 1'b1;
		d = 16'h1235;
		for (int i = 0; i < 32; i++)
			sep_bit(d[i % 16] ^ (i == 16));
		hdr_check = 1'b0;
		rd(2'h3, d);
		check("header word", 16'h1235, d);
		rd(2'h3, d);
		check("bad header", 16'h1234, d);
		rd(2'h0, d);
		check("header error", 16'h8511, d);
		clear_errors;
		wcheck_mode = 1'b1;
		dmt_wdata = 16'hfffe;
		dmt_ack = 1'b1;
		tick(1);
		dmt_ack = 1'b0;
		for (int i = 0; i < 17; i++)
			sep_bit(1'b0);
		wcheck_mode = 1'b0;
		rd(2'h0, d);
		check("write check error", 16'h8911, d);
		clear_errors;
		rd(2'h0, d);
		check("errors cleared", 16'h0111, d);
		read_mode = 1'b1;
		sep_bit(1'b1);
		read_mode = 1'b0;
		crc_check = 1'b1;
		tick(1);
		crc_check = 1'b0;
		rd(2'h0, d);
		check("crc error", 16'h8911, d);
		clear_errors;
	endtask
	task automatic t_fill;
		logic [15:0] w;
		w = 16'h0100;
		dmt_ack = 1'b1;
		for (int i = 0; i < 16; i++) begin
			dmt_wdata = w;
			w = w + 16'h0001;
			tick(1);
		end
		check("silo full", 1, silo_full);
		dmt_to_mem = 1'b1;
		w = 16'h0100;
		for (int i = 0; i < 16; i++) begin
			check("dmt read", w, dmt_rdata);
			w = w + 16'h0001;
			tick(1);
		end
		dmt_ack = 1'b0;
		dmt_to_mem = 1'b0;
		check("silo drained", 0, silo_full);
	endtask
	initial begin
		{cpu_wr, cpu_rd, dmt_ack, dmt_to_mem, pc_step_req, cmd_start, cmd_is_seek} = '0;
		{status_mode, read_mode, write_mode, wcheck_mode, hdr_check, crc_append} = '0;
		{crc_check, sector_end, clr_errors, separator_clock, separator_data} = '0;
		cpu_sel = 2'h0;
		cpu_wdata = 16'h0000;
		dmt_wdata = 16'h0000;
		ready_ctl = 1'b1;
		failures = 0;
		checks_done = 0;
		repeat (20) @(posedge core_clk);
		#1 rst_n = 1'b1;
		t_csr;
		t_dmt;
		t_status;
		t_seek;
		t_sector;
		t_serial;
		t_write;
		t_fill;
		close_out;
	end
	initial begin
		#1_000_000;
		failures++;
		close_out;
	end
endmodule
`default_nettype wire
